/* File: core/icc_core.sv */
`timescale 1ns/10ps
// How it works
// - gyro offset, 13-bit signed, added to gyro
// - accel offset, 12-bit signed, added to accel
// - autonull negates gyro outputs into offsets
// - precision autonull: offline window, refine offsets
// - restore zeroes offsets, data, updates flash
// - trigger bit self-clears after its operation
// - software reset reloads control from flash
// - reading command address starts burst read
// - bit 3 flash, bit 2 dac latch
// - misc bit 7 enables linear accel compensation
// - period is time base times increment+1
// - bit 7 picks fast or slow time base
// - period 0x0a or more means low power
// - indefinite sleep until chip select falls
// - timed sleep, half second per count
// - two cascaded averaging stages, 2^m taps
// - range bits select 300, 150, 75
// - lower ranges force minimum tap exponent
// - accel output 14-bit, clamped to full scale
// - temperature 12-bit signed, zero at 25 C
// - aux adc 12-bit offset binary
// - words are two bytes, low byte even

// -----------------------------------------
// one averaging stage
// -----------------------------------------
module icc_avg #(
	parameter int W      = 18,
	parameter int MAXLOG = 7
)(
	input  wire logic                i_clk,
	input  wire logic                i_rst,
	input  wire logic                i_ce,
	input  wire logic                i_clr,
	input  wire logic                i_vld,
	input  wire logic [2:0]          i_m,
	input  wire logic signed [W-1:0] i_d,
	output logic signed [W-1:0]      o_d,
	output logic                     o_vld
);
	typedef struct packed {
		logic [(1<<MAXLOG)-1:0][W-1:0] hist; // newest in slot 0
		logic signed [W+MAXLOG-1:0]    sum;  // running window sum
		logic [2:0]                    m;    // exponent in use
		logic signed [W-1:0]           q;    // window mean
		logic                          v;    // mean updated
	} icc_avg_t;

	icc_avg_t s_reg;
	icc_avg_t s_next;

	// window update, restart on exponent change
	always_comb begin
		logic [MAXLOG-1:0]          idx;
		logic signed [W+MAXLOG-1:0] tmp;
		idx = MAXLOG'((32'd1 << s_reg.m) - 32'd1);
		tmp = '0;
		s_next = s_reg;
		s_next.v = 1'b0;
		if (i_clr || i_m != s_reg.m) begin
			s_next.hist = '0;
			s_next.sum = '0;
			s_next.m = i_m;
		end else if (i_vld) begin
			// add newest, drop the one leaving the window
			s_next.sum = s_reg.sum + (W+MAXLOG)'(i_d)
				- (W+MAXLOG)'($signed(s_reg.hist[idx]));
			s_next.hist = {s_reg.hist[(1<<MAXLOG)-2:0], i_d};
			tmp = s_next.sum >>> s_reg.m;
			s_next.q = tmp[W-1:0];
			s_next.v = 1'b1;
		end
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_reg <= '0;
		end else if (i_ce) begin
			s_reg <= s_next;
		end
	end

	assign o_d = s_reg.q;
	assign o_vld = s_reg.v;
endmodule

// -----------------------------------------
// control and calibration top
// -----------------------------------------
module icc_core
	import icc_pkg::*;
#(
	parameter logic [20:0]        P_TB_FAST = 21'(TB_FAST_CYC),
	parameter logic [20:0]        P_TB_SLOW = 21'(TB_SLOW_CYC),
	parameter logic [25:0]        P_SLEEP   = 26'(SLEEP_CYC),
	parameter logic [31:0]        P_PREC    = 32'(PREC_CYC),
	parameter logic signed [7:0]  P_LIN_COEF = 8'sh01,
	parameter int                 P_PREC_LOG2 = 8
)(
	input  wire logic        I_CLOCK,
	input  wire logic        I_RST,
	input  wire logic        I_CE,
	input  wire logic        I_WR_STB,
	input  wire logic        I_RD_STB,
	input  wire logic [6:0]  I_ADDR,
	input  wire logic [7:0]  I_WR_BYTE,
	input  wire logic        I_CS_N,
	input  wire logic        I_EXT_SYNC,
	input  wire icc_raw_t    I_RAW,
	input  wire logic [11:0] I_AUX_DAC,
	output logic [15:0]      O_RD_DATA,
	output logic             O_RD_VALID,
	output logic             O_BURST_START,
	output icc_out_t         O_SAMPLE,
	output logic             O_NEW_DATA,
	output logic [11:0]      O_DAC_VALUE,
	output logic             O_LOW_POWER,
	output logic             O_SLEEP,
	output logic             O_BUSY,
	output logic             O_FLASH_WR
);
	localparam int SW = 18 + P_PREC_LOG2; // precision sum width

	typedef struct packed {
		icc_mode_t                  mode;     // operating mode
		logic [NCTL-1:0][15:0]      ctl;      // live control words
		logic [NCTL-1:0][15:0]      flash;    // flash copy
		logic [7:0]                 cmd;      // pending triggers
		logic [20:0]                base_cnt; // time base count
		logic [6:0]                 inc_cnt;  // increments done
		logic [2:0]                 cs_s;     // chip select sync
		logic [2:0]                 ext_s;    // ext sample sync
		logic [25:0]                half_cnt; // sleep step count
		logic [7:0]                 sleep_control;  // sleep steps left
		logic [31:0]                prec_cnt; // precision window
		logic [P_PREC_LOG2:0]       prec_n;   // samples summed
		logic [2:0][SW-1:0]         prec_sum; // gyro sums
		logic                       clr;      // zero filters
		logic                       tick;     // sample taken
		icc_out_t                   smp;      // output words
		logic                       nd;       // new data pulse
		logic [15:0]                rd_data;  // read answer
		logic                       rd_v;     // read valid
		logic                       burst;    // burst start
		logic [11:0]                dac;      // latched dac word
		logic                       fl_wr;    // flash written
		logic                       lowpwr;   // low power mode
		logic                       slp;      // sleeping, registered
		logic                       busy;     // not running, registered
	} icc_core_t;

	icc_core_t s_reg;
	icc_core_t s_next;

	logic signed [17:0] comp [6];  // corrected sensor values
	logic signed [17:0] fmid [6];  // first stage means
	logic signed [17:0] favg [6];  // second stage means
	logic               vmid [6];  // first stage valid
	logic               vavg [6];  // second stage valid

	// ---------------------------------
	// helpers
	// ---------------------------------
	// gyro output shift for the range
	function automatic logic [1:0] rshift(input logic [2:0] r);
		case (r)
			RNG_75:  rshift = 2'd0;
			RNG_150: rshift = 2'd1;
			default: rshift = 2'd2;
		endcase
	endfunction

	// limit to a 13-bit offset
	function automatic logic [12:0] sat13(input logic signed [17:0] v);
		if (v > 18'sd4095) sat13 = 13'h0fff;
		else if (v < -18'sd4096) sat13 = 13'h1000;
		else sat13 = v[12:0];
	endfunction

	// limit to a 14-bit gyro output
	function automatic logic [13:0] sat14(input logic signed [17:0] v);
		if (v > 18'sd8191) sat14 = 14'h1fff;
		else if (v < -18'sd8192) sat14 = 14'h2000;
		else sat14 = v[13:0];
	endfunction

	// raise the tap exponent for low ranges
	function automatic logic [15:0] tapfix(input logic [15:0] w);
		tapfix = w;
		if (w[10:8] == RNG_150 && w[2:0] < TAP_MIN_150) begin
			tapfix[2:0] = TAP_MIN_150;
		end
		if (w[10:8] == RNG_75 && w[2:0] < TAP_MIN_75) begin
			tapfix[2:0] = TAP_MIN_75;
		end
	endfunction

	// byte address to control word index
	function automatic logic [3:0] cidx(input logic [6:0] a);
		logic [6:0] w;
		w = {a[6:1], 1'b0};
		cidx = R_NONE;
		if (w >= A_OFF_BASE && w <= A_OFF_LAST) begin
			cidx = 4'((w - A_OFF_BASE) >> 1);
		end else if (w == A_MISC) cidx = 4'(R_MISC);
		else if (w == A_SMPL) cidx = 4'(R_SMPL);
		else if (w == A_SENS) cidx = 4'(R_SENS);
	endfunction

	// ---------------------------------
	// correction and filtering
	// ---------------------------------
	for (genvar g = 0; g < 3; g++) begin : g_corr
		logic signed [17:0] lin; // linear accel share of gyro bias
		assign lin = s_reg.ctl[R_MISC][MISC_LINC]
			? (18'($signed(I_RAW.accel[g])) * 18'(P_LIN_COEF)) >>> LIN_SHIFT
			: 18'sd0;
		assign comp[g] = 18'($signed(I_RAW.gyro[g]))
			+ 18'($signed(s_reg.ctl[g][12:0])) - lin;
		assign comp[g+3] = 18'($signed(I_RAW.accel[g]))
			+ 18'($signed(s_reg.ctl[g+3][11:0]));
	end

	for (genvar g = 0; g < 6; g++) begin : g_filt
		icc_avg #(.W(18), .MAXLOG(7)) u_st1 (
			.i_clk (I_CLOCK),
			.i_rst (I_RST),
			.i_ce  (I_CE),
			.i_clr (s_reg.clr),
			.i_vld (s_reg.tick),
			.i_m   (s_reg.ctl[R_SENS][2:0]),
			.i_d   (comp[g]),
			.o_d   (fmid[g]),
			.o_vld (vmid[g])
		);
		icc_avg #(.W(18), .MAXLOG(7)) u_st2 (
			.i_clk (I_CLOCK),
			.i_rst (I_RST),
			.i_ce  (I_CE),
			.i_clr (s_reg.clr),
			.i_vld (vmid[g]),
			.i_m   (s_reg.ctl[R_SENS][2:0]),
			.i_d   (fmid[g]),
			.o_d   (favg[g]),
			.o_vld (vavg[g])
		);
	end

	// ---------------------------------
	// next state
	// ---------------------------------
	always_comb begin
		logic               cs_fall;
		logic               ext_rise;
		logic [20:0]        base_lim;
		logic [1:0]         sh;
		logic [3:0]         ix;
		logic [6:0]         w;
		logic signed [17:0] d;
		logic signed [SW-1:0] avg;
		cs_fall = 1'b0;
		ext_rise = 1'b0;
		base_lim = '0;
		sh = '0;
		ix = '0;
		w = '0;
		d = '0;
		avg = '0;
		s_next = s_reg;
		s_next.nd = 1'b0;
		s_next.rd_v = 1'b0;
		s_next.burst = 1'b0;
		s_next.fl_wr = 1'b0;
		s_next.tick = 1'b0;
		s_next.clr = 1'b0;
		// pin synchronisers, edges from stages 2 and 3
		s_next.cs_s = {s_reg.cs_s[1:0], I_CS_N};
		s_next.ext_s = {s_reg.ext_s[1:0], I_EXT_SYNC};
		cs_fall = s_reg.cs_s[2] & ~s_reg.cs_s[1];
		ext_rise = ~s_reg.ext_s[2] & s_reg.ext_s[1];
		sh = rshift(s_reg.ctl[R_SENS][10:8]);
		s_next.lowpwr = s_reg.ctl[R_SMPL][7:0] >= SMPL_LOWPWR;

		// sample timer, runs while sensing
		base_lim = s_reg.ctl[R_SMPL][SMPL_TB] ? P_TB_SLOW - 21'd1
			: P_TB_FAST - 21'd1;
		if (s_reg.mode == M_RUN || s_reg.mode == M_PREC) begin
			if (s_reg.ctl[R_SMPL][7:0] == 8'h00) begin
				s_next.tick = ext_rise; // external sample clock
			end else if (s_reg.base_cnt >= base_lim) begin
				s_next.base_cnt = '0;
				if (s_reg.inc_cnt >= s_reg.ctl[R_SMPL][6:0]) begin
					s_next.inc_cnt = '0;
					s_next.tick = 1'b1;
				end else begin
					s_next.inc_cnt = s_reg.inc_cnt + 7'h01;
				end
			end else begin
				s_next.base_cnt = s_reg.base_cnt + 21'h000001;
			end
		end

		// filtered sample lands in the output words
		if (vavg[0] && s_reg.mode == M_RUN) begin
			for (int i = 0; i < 3; i++) begin
				s_next.smp.gyro[i] = sat14(favg[i] >>> sh);
				if (favg[i+3] > ACC_FS) s_next.smp.accel[i] = ACC_FS[13:0];
				else if (favg[i+3] < -ACC_FS) s_next.smp.accel[i] = 14'(-ACC_FS);
				else s_next.smp.accel[i] = favg[i+3][13:0];
				s_next.smp.temp[i] = I_RAW.temp[i];
			end
			s_next.smp.aux = I_RAW.aux;
			s_next.nd = 1'b1;
		end

		// mode machine
		case (s_reg.mode)
			M_RUN: begin
				if (s_reg.cmd[CMD_SWRST]) begin
					s_next.mode = M_START;
				end else if (s_reg.cmd[CMD_PREC]) begin
					s_next.mode = M_PREC;
					s_next.prec_cnt = '0;
					s_next.prec_n = '0;
					s_next.prec_sum = '0;
				end else if (s_reg.cmd[CMD_AUTO]) begin
					for (int i = 0; i < 3; i++) begin
						d = 18'($signed(s_reg.ctl[i][12:0]))
							- (18'($signed(s_reg.smp.gyro[i])) <<< sh);
						s_next.ctl[i] = {3'b000, sat13(d)};
					end
					s_next.smp = '0;
					s_next.clr = 1'b1;
					s_next.mode = M_FLASH;
				end else if (s_reg.cmd[CMD_REST]) begin
					for (int i = 0; i < 6; i++) begin
						s_next.ctl[i] = 16'h0000;
					end
					s_next.smp = '0;
					s_next.clr = 1'b1;
					s_next.mode = M_FLASH;
				end else if (s_reg.cmd[CMD_FLASH]) begin
					s_next.mode = M_FLASH;
				end else if (s_reg.cmd[CMD_DAC]) begin
					s_next.dac = I_AUX_DAC;
					s_next.cmd[CMD_DAC] = 1'b0;
				end
			end
			M_START: begin
				// restart: reload control, drop stale data
				s_next.ctl = s_reg.flash;
				s_next.smp = '0;
				s_next.clr = 1'b1;
				s_next.base_cnt = '0;
				s_next.inc_cnt = '0;
				s_next.cmd[CMD_SWRST] = 1'b0;
				s_next.mode = M_RUN;
			end
			M_PREC: begin
				s_next.prec_cnt = s_reg.prec_cnt + 32'h00000001;
				if (s_reg.tick && !s_reg.prec_n[P_PREC_LOG2]) begin
					for (int i = 0; i < 3; i++) begin
						s_next.prec_sum[i] = s_reg.prec_sum[i] + SW'(comp[i]);
					end
					s_next.prec_n = s_reg.prec_n + 1'b1;
				end
				if (s_reg.prec_cnt >= P_PREC - 32'h00000001) begin
					for (int i = 0; i < 3; i++) begin
						avg = $signed(s_reg.prec_sum[i]) >>> P_PREC_LOG2;
						d = 18'($signed(s_reg.ctl[i][12:0])) - avg[17:0];
						if (s_reg.prec_n[P_PREC_LOG2]) begin
							s_next.ctl[i] = {3'b000, sat13(d)};
						end
					end
					s_next.smp = '0;
					s_next.clr = 1'b1;
					s_next.mode = M_FLASH;
				end
			end
			M_FLASH: begin
				s_next.flash = s_reg.ctl;
				s_next.fl_wr = 1'b1;
				s_next.cmd = s_reg.cmd & 8'he4;
				s_next.mode = M_RUN;
			end
			M_SLP_T: begin
				if (s_reg.half_cnt >= P_SLEEP - 26'd1) begin
					s_next.half_cnt = '0;
					s_next.sleep_control = s_reg.sleep_control - 8'h01;
					if (s_reg.sleep_control == 8'h01) s_next.mode = M_RUN;
				end else begin
					s_next.half_cnt = s_reg.half_cnt + 26'd1;
				end
			end
			M_SLP_I: begin
				if (cs_fall) s_next.mode = M_RUN;
			end
			default: begin
				s_next.mode = M_RUN;
			end
		endcase

		// host read, one word per request
		if (I_RD_STB) begin
			w = {I_ADDR[6:1], 1'b0};
			ix = cidx(I_ADDR);
			if (w == A_CMD) begin
				s_next.burst = 1'b1;
			end else begin
				s_next.rd_v = 1'b1;
				if (ix != R_NONE) s_next.rd_data = s_reg.ctl[ix];
				else if (w >= A_OUT_BASE && w <= A_OUT_LAST) begin
					ix = 4'((w - A_OUT_BASE) >> 1);
					if (ix < 4'd3) s_next.rd_data = {2'b00, s_reg.smp.gyro[ix]};
					else if (ix < 4'd6) s_next.rd_data = {2'b00, s_reg.smp.accel[ix - 4'd3]};
					else if (ix < 4'd9) s_next.rd_data = {4'h0, s_reg.smp.temp[ix - 4'd6]};
					else s_next.rd_data = {4'h0, s_reg.smp.aux};
				end else s_next.rd_data = 16'h0000; // unmapped or write only
			end
		end

		// host byte write, applied last so a set beats a clear
		if (I_WR_STB) begin
			ix = cidx(I_ADDR);
			if (I_ADDR == A_CMD) begin
				s_next.cmd = s_next.cmd | (I_WR_BYTE & CMD_MASK);
			end else if (I_ADDR == A_SLEEP) begin
				if (I_WR_BYTE != 8'h00 && s_reg.mode == M_RUN) begin
					s_next.mode = M_SLP_T;
					s_next.sleep_control = I_WR_BYTE;
					s_next.half_cnt = '0;
				end
			end else if (I_ADDR == A_SLEEP + 7'd1) begin
				if (I_WR_BYTE[SLP_INDEF] && s_reg.mode == M_RUN) begin
					s_next.mode = M_SLP_I;
				end
			end else if (ix != R_NONE) begin
				if (I_ADDR[0]) s_next.ctl[ix][15:8] = I_WR_BYTE;
				else s_next.ctl[ix][7:0] = I_WR_BYTE;
				s_next.ctl[ix] = s_next.ctl[ix] & CTL_MASK[ix];
				if (ix == 4'(R_SENS)) s_next.ctl[ix] = tapfix(s_next.ctl[ix]);
			end
		end

		// status flags follow the next mode so the pins come from flops
		s_next.slp = s_next.mode == M_SLP_T || s_next.mode == M_SLP_I;
		s_next.busy = s_next.mode != M_RUN;
	end

	// ---------------------------------
	// state register
	// ---------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			s_reg <= '0;
			s_reg.mode <= M_RUN;
			s_reg.ctl <= CTL_RST;
			s_reg.flash <= CTL_RST;
			s_reg.cs_s <= 3'b111;
		end else if (I_CE) begin
			s_reg <= s_next;
		end
	end

	assign O_RD_DATA = s_reg.rd_data;
	assign O_RD_VALID = s_reg.rd_v;
	assign O_BURST_START = s_reg.burst;
	assign O_SAMPLE = s_reg.smp;
	assign O_NEW_DATA = s_reg.nd;
	assign O_DAC_VALUE = s_reg.dac;
	assign O_LOW_POWER = s_reg.lowpwr;
	assign O_SLEEP = s_reg.slp;
	assign O_BUSY = s_reg.busy;
	assign O_FLASH_WR = s_reg.fl_wr;

	// ---------------------------------
	// checks
	// ---------------------------------
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);

	swreset_seq_a: assert property (I_CE && s_reg.mode == M_RUN && s_reg.cmd[CMD_SWRST]
		|=> s_reg.mode == M_START) else $error("software reset did not start");
	flash_clear_a: assert property (I_CE && s_reg.mode == M_FLASH && !I_WR_STB
		|=> s_reg.cmd[4:3] == 2'b00 && s_reg.cmd[1:0] == 2'b00 && s_reg.fl_wr)
		else $error("triggers not cleared after flash");
	burst_read_a: assert property (I_CE && I_RD_STB && I_ADDR[6:1] == A_CMD[6:1]
		|=> O_BURST_START && !O_RD_VALID) else $error("burst start missing");
	range150_taps_a: assert property (s_reg.ctl[R_SENS][10:8] == RNG_150
		|-> s_reg.ctl[R_SENS][2:0] >= TAP_MIN_150) else $error("150 range taps low");
	range75_taps_a: assert property (s_reg.ctl[R_SENS][10:8] == RNG_75
		|-> s_reg.ctl[R_SENS][2:0] >= TAP_MIN_75) else $error("75 range taps low");
	prec_hold_a: assert property (s_reg.mode == M_PREC ##1 s_reg.mode == M_PREC
		|-> !O_NEW_DATA && $stable(O_SAMPLE)) else $error("outputs moved in precision");
	restore_zero_a: assert property (I_CE && s_reg.mode == M_RUN && !s_reg.cmd[CMD_SWRST]
		&& !s_reg.cmd[CMD_PREC] && !s_reg.cmd[CMD_AUTO] && s_reg.cmd[CMD_REST] && !I_WR_STB
		|=> s_reg.ctl[5:0] == '0 ##1 O_FLASH_WR) else $error("restore left offsets");
	lowpwr_mode_a: assert property (I_CE && s_reg.ctl[R_SMPL][7:0] >= SMPL_LOWPWR
		&& $stable(s_reg.ctl[R_SMPL]) |=> O_LOW_POWER) else $error("low power not entered");
	indef_wake_a: assert property (I_CE && s_reg.mode == M_SLP_I && s_reg.cs_s[2]
		&& !s_reg.cs_s[1] |=> s_reg.mode == M_RUN) else $error("no wake on chip select");
endmodule

/* File: core/icc_pkg.sv */
package icc_pkg;
	// ---------------------------------
	// clock and timing
	// ---------------------------------
	localparam real CLK_MHZ    = 100.0;     // core clock rate
	localparam real TB_FAST_MS = 0.61035;   // fast sample time base
	localparam real TB_SLOW_MS = 18.921;    // slow sample time base
	localparam real SLEEP_S    = 0.5;       // one timed sleep step
	localparam real PREC_S     = 30.0;      // precision autonull window
	localparam int  TB_FAST_CYC  = int'(TB_FAST_MS * CLK_MHZ * 1000.0);
	localparam int  TB_SLOW_CYC  = int'(TB_SLOW_MS * CLK_MHZ * 1000.0);
	localparam int  SLEEP_CYC    = int'(SLEEP_S * CLK_MHZ * 1.0e6);
	localparam longint PREC_CYC  = longint'(PREC_S * CLK_MHZ * 1.0e6);

	// ---------------------------------
	// byte addresses, low byte shown
	// ---------------------------------
	localparam logic [6:0] A_OUT_BASE = 7'h04; // first sensor output
	localparam logic [6:0] A_OUT_LAST = 7'h16; // auxiliary adc output
	localparam logic [6:0] A_OFF_BASE = 7'h1a; // gyro x bias offset
	localparam logic [6:0] A_OFF_LAST = 7'h24; // accel z bias offset
	localparam logic [6:0] A_MISC     = 7'h34; // miscellaneous_control
	localparam logic [6:0] A_SMPL     = 7'h36; // sample_period_setting
	localparam logic [6:0] A_SENS     = 7'h38; // range_and_filter_control
	localparam logic [6:0] A_SLEEP    = 7'h3a; // sleep_control
	localparam logic [6:0] A_CMD      = 7'h3e; // global_command_triggers

	// ---------------------------------
	// control register file
	// ---------------------------------
	localparam int NCTL   = 9;    // stored, flash backed words
	localparam int R_MISC = 6;    // index of miscellaneous_control
	localparam int R_SMPL = 7;    // index of sample_period_setting
	localparam int R_SENS = 8;    // index of range_and_filter_control
	localparam logic [3:0] R_NONE = 4'hf; // not a control word
	localparam logic [NCTL-1:0][15:0] CTL_RST = {16'h0402, 16'h0001, 16'h0006,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	localparam logic [NCTL-1:0][15:0] CTL_MASK = {16'h0707, 16'h00ff, 16'h0fc7,
		16'h0fff, 16'h0fff, 16'h0fff, 16'h1fff, 16'h1fff, 16'h1fff};

	// ---------------------------------
	// field positions and values
	// ---------------------------------
	localparam int CMD_AUTO  = 0;         // autonull
	localparam int CMD_REST  = 1;         // factory restore
	localparam int CMD_DAC   = 2;         // dac latch
	localparam int CMD_FLASH = 3;         // flash update
	localparam int CMD_PREC  = 4;         // precision autonull
	localparam int CMD_SWRST = 7;         // software reset
	localparam logic [7:0] CMD_MASK = 8'h9f; // live trigger bits
	localparam int MISC_LINC = 7;         // linear accel compensation
	localparam int SMPL_TB   = 7;         // time base select
	localparam logic [7:0] SMPL_LOWPWR = 8'h0a; // low power threshold
	localparam int SLP_INDEF = 0;         // bit 8, in high byte
	localparam logic [2:0] RNG_300 = 3'b100;
	localparam logic [2:0] RNG_150 = 3'b010;
	localparam logic [2:0] RNG_75  = 3'b001;
	localparam logic [2:0] TAP_MIN_150 = 3'h2;
	localparam logic [2:0] TAP_MIN_75  = 3'h4;
	localparam int LIN_SHIFT = 4;         // lin comp coefficient scale
	localparam logic signed [17:0] ACC_FS = 18'sd5401; // accel full scale

	// ---------------------------------
	// types
	// ---------------------------------
	typedef enum logic [2:0] {
		M_RUN   = 3'b000,
		M_START = 3'b001,
		M_PREC  = 3'b011,
		M_FLASH = 3'b101,
		M_SLP_T = 3'b110,
		M_SLP_I = 3'b111
	} icc_mode_t;

	typedef struct packed {
		logic [2:0][15:0] gyro;   // signed, 0.0125 deg/s per lsb
		logic [2:0][13:0] accel;  // signed, 3.333 mg per lsb
		logic [2:0][11:0] temp;   // signed, 0 = 25 C
		logic [11:0]      aux;    // offset binary
	} icc_raw_t;

	typedef struct packed {
		logic [2:0][13:0] gyro;
		logic [2:0][13:0] accel;
		logic [2:0][11:0] temp;
		logic [11:0]      aux;
	} icc_out_t;
endpackage

/* File: bench/icc_host.sv */
`timescale 1ns/10ps
// host model: byte writes, word reads
module icc_host (
	input  wire logic        i_clk,
	input  wire logic [15:0] i_rd_data,
	output logic             o_wr_stb,
	output logic             o_rd_stb,
	output logic [6:0]       o_addr,
	output logic [7:0]       o_wr_byte
);
	initial begin
		o_wr_stb = 1'b0;
		o_rd_stb = 1'b0;
		o_addr = 7'h00;
		o_wr_byte = 8'h00;
	end
	// one byte per strobe, released lines show inverse
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge i_clk);
		#1;
		o_wr_stb = 1'b1;
		o_addr = a;
		o_wr_byte = d;
		@(posedge i_clk);
		#1;
		o_wr_stb = 1'b0;
		o_addr = ~a;
		o_wr_byte = ~d;
	endtask
	// answer sampled one edge after the request
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		@(posedge i_clk);
		#1;
		o_rd_stb = 1'b1;
		o_addr = a;
		@(posedge i_clk);
		#1;
		o_rd_stb = 1'b0;
		o_addr = ~a;
		d = i_rd_data;
	endtask
endmodule

/* File: bench/tb_icc_core.sv */
`timescale 1ns/10ps
module tb_icc_core;
	import icc_pkg::*;
	logic clk = 1'b0, rst = 1'b1, wr, rd, bst, lp, fw, vld;
	logic ce = 1'b1, cs_n = 1'b1, nd, slp, bsy;
	icc_out_t smp;
	logic [6:0]  adr;
	logic [7:0]  wb;
	logic [11:0] dac_in = 12'h4d9, dac;
	logic [15:0] rdd, v;
	int miscompares = 0, checked = 0, cyc = 0;
	always #5 clk = ~clk;
	icc_host i_icc_host (.i_clk(clk), .i_rd_data(rdd), .o_wr_stb(wr), .o_rd_stb(rd), .o_addr(adr), .o_wr_byte(wb));
	icc_core #(.P_TB_FAST(21'h8), .P_TB_SLOW(21'h14), .P_SLEEP(26'ha), .P_PREC(32'hc8), .P_PREC_LOG2(2)) i_icc_core (
		.I_CLOCK(clk), .I_RST(rst), .I_CE(ce), .I_WR_STB(wr), .I_RD_STB(rd), .I_ADDR(adr),
		.I_WR_BYTE(wb), .I_CS_N(cs_n), .I_EXT_SYNC(1'b0), .I_RAW('0), .I_AUX_DAC(dac_in),
		.O_RD_DATA(rdd), .O_RD_VALID(vld), .O_BURST_START(bst), .O_SAMPLE(smp), .O_NEW_DATA(nd),
		.O_DAC_VALUE(dac), .O_LOW_POWER(lp), .O_SLEEP(slp), .O_BUSY(bsy), .O_FLASH_WR(fw));
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wrap_up;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wait_flash(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
			if (fw === 1'b1) break;
		end
		chk({15'h0, fw}, 16'h1);
	endtask
	task automatic t_reset_vals;
		i_icc_host.rd(7'h36, v); chk(v, 16'h0001);
		chk({15'h0, vld}, 16'h0001);
		i_icc_host.rd(7'h38, v); chk(v, 16'h0402);
		i_icc_host.rd(7'h3e, v); chk({14'h0, bst, vld}, 16'h0002);
	endtask
	task automatic t_offsets;
		i_icc_host.wr(7'h1b, 8'h1f); i_icc_host.wr(7'h1a, 8'hf6);
		i_icc_host.rd(7'h1a, v); chk(v, 16'h1ff6);
		i_icc_host.wr(7'h21, 8'hff); i_icc_host.wr(7'h20, 8'hff);
		i_icc_host.rd(7'h20, v); chk(v, 16'h0fff);
	endtask
	task automatic t_soft_reset;
		i_icc_host.wr(7'h3e, 8'h80);
		repeat (6) @(posedge clk);
		i_icc_host.rd(7'h1a, v); chk(v, 16'h0000);
	endtask
	task automatic t_restore;
		i_icc_host.wr(7'h1c, 8'h33); i_icc_host.wr(7'h3e, 8'h00);
		i_icc_host.rd(7'h1c, v); chk(v, 16'h0033);
		i_icc_host.wr(7'h3e, 8'h02); wait_flash(20);
		i_icc_host.rd(7'h1c, v); chk(v, 16'h0000);
	endtask
	task automatic t_cal;
		int n;
		n = 0;
		i_icc_host.wr(7'h1b, 8'h1f); i_icc_host.wr(7'h1a, 8'hd8);
		repeat (160) begin
			@(posedge clk);
			#1;
			if (nd === 1'b1) n++;
		end
		chk(16'(n), 16'h000a);
		chk({2'h0, smp.gyro[0]}, 16'h3ff6);
		i_icc_host.rd(7'h04, v); chk(v, 16'h3ff6);
		i_icc_host.wr(7'h3e, 8'h01); wait_flash(20);
		chk({2'h0, smp.gyro[0]}, 16'h0000);
		i_icc_host.rd(7'h1a, v); chk(v, 16'h0000);
		i_icc_host.wr(7'h1b, 8'h1f); i_icc_host.wr(7'h1a, 8'hd8);
		i_icc_host.wr(7'h3e, 8'h10);
		@(posedge clk);
		n = 0;
		repeat (150) begin
			@(posedge clk);
			#1;
			if (nd === 1'b1) n++;
			if (bsy !== 1'b1) n++;
		end
		chk(16'(n), 16'h0000);
		wait_flash(100);
		i_icc_host.rd(7'h1a, v); chk(v, 16'h0000);
	endtask
	task automatic t_sleep;
		@(posedge clk);
		#1 ce = 1'b0;
		i_icc_host.wr(7'h3a, 8'h02);
		ce = 1'b1;
		chk({14'h0, slp, bsy}, 16'h0000);
		i_icc_host.wr(7'h3a, 8'h02);
		repeat (19) @(posedge clk);
		#1 chk({14'h0, slp, bsy}, 16'h0003);
		@(posedge clk);
		#1 chk({14'h0, slp, bsy}, 16'h0000);
		i_icc_host.wr(7'h3b, 8'h01);
		repeat (5) @(posedge clk);
		#1 chk({14'h0, slp, bsy}, 16'h0003);
		cs_n = 1'b0;
		repeat (3) @(posedge clk);
		#1 chk({14'h0, slp, bsy}, 16'h0000);
		cs_n = 1'b1;
	endtask
	task automatic t_misc;
		i_icc_host.wr(7'h3e, 8'h04);
		repeat (3) @(posedge clk);
		#1 chk({4'h0, dac}, 16'h04d9);
		i_icc_host.wr(7'h39, 8'h01);
		i_icc_host.rd(7'h38, v); chk(v, 16'h0104);
		i_icc_host.wr(7'h36, 8'h0a);
		repeat (2) @(posedge clk);
		#1 chk({15'h0, lp}, 16'h1);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			wrap_up();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		t_reset_vals();
		t_offsets();
		t_soft_reset();
		t_restore();
		t_cal();
		t_sleep();
		t_misc();
		wrap_up();
	end
endmodule
